// File: shared/flk_regs.svh
// register offsets, fields, reset values and command codes
`ifndef FLK_REGS_SVH
`define FLK_REGS_SVH
`define FLK_OFS_PROG 8'h00
`define FLK_OFS_ERS 8'h04
`define FLK_OFS_STAT 8'h08
`define FLK_OFS_LOCK 8'h0C
`define FLK_PROG_RST 16'h0010
`define FLK_ERS_RST 16'h0020
`define FLK_CMD_C1 16'h00AA
`define FLK_CMD_C2 16'h0055
`define FLK_CMD_PROG 16'h00A0
`define FLK_CMD_ERS 16'h0080
`define FLK_CMD_ID 16'h0090
`define FLK_CMD_EXIT 16'h00F0
`define FLK_CMD_CHIP 16'h0010
`define FLK_CMD_PLANE 16'h0020
`define FLK_CMD_SECT 16'h0030
`define FLK_CMD_SOFT 16'h0040
`define FLK_CMD_HARD 16'h0050
`define FLK_CMD_UNL1 16'h0060
`define FLK_CMD_UNL2 16'h00D0
`define FLK_LOCK_OFS 2'h2
`define FLK_ST_RDY 7
`define FLK_ST_FAIL 5
`define FLK_RESP_OK 2'h0
`define FLK_RESP_ERR 2'h2
`endif

// File: shared/flk_pkg.sv
// types shared by the flash sequencer and its register slave
`include "flk_regs.svh"
package flk_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } flk_regreq_type;
  typedef enum logic [3:0] {SQ_IDLE, SQ_C1, SQ_C2, SQ_PGM, SQ_E3, SQ_E4,
    SQ_E5, SQ_UNL} flk_seq_type;
  typedef enum logic [1:0] {MD_READ, MD_ID, MD_STAT} flk_mode_type;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} flk_op_type;
  typedef enum logic [3:0] {EV_NONE, EV_PROG, EV_CHIP, EV_PLANE, EV_SECT,
    EV_SOFT, EV_HARD, EV_UNLOCK, EV_ID, EV_EXIT} flk_ev_type;
  function automatic logic flk_addr_ok(input logic [7:0] a);
    return a == `FLK_OFS_PROG || a == `FLK_OFS_ERS ||
      a == `FLK_OFS_STAT || a == `FLK_OFS_LOCK;
  endfunction
endpackage

// File: hdl/flk_axil.sv
// axi4-lite slave front end for the sequencer registers
`timescale 1ns/1ps
`include "flk_regs.svh"
module flk_axil import flk_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output flk_regreq_type wreq,
  output logic [7:0] raddr,
  input wire logic [31:0] rdata_in
);
  logic [7:0] wa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic rpend_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `FLK_RESP_OK;
      wreq <= '0;
      wa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
    end else begin
      wreq.wr <= 1'b0;
      if (awvalid && awready) begin
        awready <= 1'b0;
        wa_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd_r <= wdata;
        ws_r <= wstrb;
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= flk_addr_ok(wa_r) ? `FLK_RESP_OK : `FLK_RESP_ERR;
        wreq <= '{wr: 1'b1, addr: wa_r, data: wd_r, strb: ws_r};
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rpend_r <= 1'b0;
      raddr <= '0;
      rdata <= '0;
      rresp <= `FLK_RESP_OK;
    end else begin
      rpend_r <= 1'b0;
      if (arvalid && arready) begin
        arready <= 1'b0;
        raddr <= araddr;
        rpend_r <= 1'b1;
      end
      if (rpend_r) begin
        rvalid <= 1'b1;
        rdata <= flk_addr_ok(raddr) ? rdata_in : '0;
        rresp <= flk_addr_ok(raddr) ? `FLK_RESP_OK : `FLK_RESP_ERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

// File: hdl/flk_top.sv
// flash erase, word program and sector lock sequencer
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "flk_regs.svh"
module flk_top import flk_pkg::*; #(
  parameter int DW = 16,
  parameter int NSECT = 8,
  parameter int SECT_AW = 2,
  parameter int PLANE_SECT = 4,
  parameter int AW = SECT_AW + $clog2(NSECT)
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic RESET_N,
  input wire logic WE_N,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WP,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] DQ_I,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  localparam int SW = $clog2(NSECT);
  localparam int PW = SECT_AW + $clog2(PLANE_SECT);
  localparam int NWORD = 1 << AW;
  localparam int PN = 5 + AW + DW;
  logic [PN-1:0] pin1_r, pin2_r;
  logic rst_n_s, we_n_s, ce_n_s, oe_n_s, wp_s;
  logic [AW-1:0] a_s;
  logic [DW-1:0] d_s;
  logic rst, wact, wact_d_r, cyc_end;
  logic [AW-1:0] ca_r;
  logic [SW-1:0] csec, psec, rsec;
  logic [NSECT-1:0] prot, pmask;
  logic [DW-1:0] mem [NWORD];
  logic [NSECT-1:0] soft_r, hard_r, emask_r;
  flk_seq_type seq_r, seq_nxt;
  flk_ev_type ev;
  flk_mode_type mode_r;
  flk_op_type op_r;
  logic fail_r;
  logic [15:0] cnt_r;
  logic [AW-1:0] ptr_r, end_r;
  logic [DW-1:0] pd_r;
  logic [15:0] prog_cyc_r, ers_cyc_r;
  logic step;
  flk_regreq_type wreq;
  logic [7:0] raddr;
  logic [31:0] rd_mux;
  // pin synchronisers
  always_ff @(posedge CORE_CLK) begin
    pin1_r <= {RESET_N, WE_N, CE_N, OE_N, WP, ADDR, DQ_I};
    pin2_r <= pin1_r;
  end
  assign {rst_n_s, we_n_s, ce_n_s, oe_n_s, wp_s, a_s, d_s} = pin2_r;
  assign rst = SRST | ~rst_n_s;
  assign wact = ~we_n_s & ~ce_n_s;
  assign cyc_end = wact_d_r & ~wact;
  // address taken at strobe fall, data at strobe rise
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      wact_d_r <= 1'b0;
      ca_r <= '0;
    end else begin
      wact_d_r <= wact;
      if (wact && !wact_d_r) begin
        ca_r <= a_s;
      end
    end
  end

  assign csec = ca_r[AW-1 -: SW];
  assign psec = ptr_r[AW-1 -: SW];
  assign rsec = a_s[AW-1 -: SW];
  assign prot = soft_r | (hard_r & {NSECT{~wp_s}});

  genvar gs;
  generate
    for (gs = 0; gs < NSECT; gs++) begin : g_plane
      assign pmask[gs] = (gs / PLANE_SECT) ==
        int'(ca_r[AW-1:PW]);
    end
  endgenerate

  // command sequence decode
  always_comb begin
    seq_nxt = seq_r;
    ev = EV_NONE;
    if (cyc_end && op_r == OP_IDLE) begin
      seq_nxt = SQ_IDLE;
      unique case (seq_r)
        SQ_IDLE: begin
          if (d_s == `FLK_CMD_C1) begin
            seq_nxt = SQ_C1;
          end else if (d_s == `FLK_CMD_UNL1) begin
            seq_nxt = SQ_UNL;
          end else if (d_s == `FLK_CMD_EXIT) begin
            ev = EV_EXIT;
          end
        end
        SQ_C1: if (d_s == `FLK_CMD_C2) seq_nxt = SQ_C2;
        SQ_C2: begin
          if (d_s == `FLK_CMD_PROG) begin
            seq_nxt = SQ_PGM;
          end else if (d_s == `FLK_CMD_ERS) begin
            seq_nxt = SQ_E3;
          end else if (d_s == `FLK_CMD_ID) begin
            ev = EV_ID;
          end
        end
        SQ_PGM: ev = EV_PROG;
        SQ_E3: if (d_s == `FLK_CMD_C1) seq_nxt = SQ_E4;
        SQ_E4: if (d_s == `FLK_CMD_C2) seq_nxt = SQ_E5;
        SQ_E5: begin
          if (d_s == `FLK_CMD_CHIP) begin
            ev = EV_CHIP;
          end else if (d_s == `FLK_CMD_PLANE) begin
            ev = EV_PLANE;
          end else if (d_s == `FLK_CMD_SECT) begin
            ev = EV_SECT;
          end else if (d_s == `FLK_CMD_SOFT) begin
            ev = EV_SOFT;
          end else if (d_s == `FLK_CMD_HARD) begin
            ev = EV_HARD;
          end
        end
        SQ_UNL: if (d_s == `FLK_CMD_UNL2) ev = EV_UNLOCK;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      seq_r <= SQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // sector locks
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      soft_r <= '1;
      hard_r <= '0;
    end else begin
      if (ev == EV_SOFT) soft_r[csec] <= 1'b1;
      if (ev == EV_HARD) hard_r[csec] <= 1'b1;
      if (ev == EV_UNLOCK && !(hard_r[csec] && !wp_s)) begin
        soft_r[csec] <= 1'b0;
      end
    end
  end

  assign step = op_r != OP_IDLE && cnt_r == '0;

  // operation engine and device mode
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      op_r <= OP_IDLE;
      mode_r <= MD_READ;
      fail_r <= 1'b0;
      cnt_r <= '0;
      ptr_r <= '0;
      end_r <= '0;
      emask_r <= '0;
      pd_r <= '0;
    end else if (op_r != OP_IDLE) begin
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - 16'h0001;
      end else if (op_r == OP_PROG || ptr_r == end_r) begin
        op_r <= OP_IDLE;
        mode_r <= MD_READ;
      end else begin
        ptr_r <= ptr_r + 1'b1;
        cnt_r <= ers_cyc_r;
      end
    end else begin
      unique case (ev)
        EV_PROG: begin
          mode_r <= MD_STAT;
          if (prot[csec]) begin
            fail_r <= 1'b1;
          end else begin
            op_r <= OP_PROG;
            ptr_r <= ca_r;
            pd_r <= d_s;
            cnt_r <= prog_cyc_r;
          end
        end
        EV_CHIP: begin
          mode_r <= MD_STAT;
          op_r <= OP_ERASE;
          ptr_r <= '0;
          end_r <= '1;
          emask_r <= ~prot;
          cnt_r <= ers_cyc_r;
        end
        EV_PLANE: begin
          mode_r <= MD_STAT;
          if (|(prot & pmask)) begin
            fail_r <= 1'b1;
          end else begin
            op_r <= OP_ERASE;
            ptr_r <= {ca_r[AW-1:PW], {PW{1'b0}}};
            end_r <= {ca_r[AW-1:PW], {PW{1'b1}}};
            emask_r <= pmask;
            cnt_r <= ers_cyc_r;
          end
        end
        EV_SECT: begin
          mode_r <= MD_STAT;
          if (prot[csec]) begin
            fail_r <= 1'b1;
          end else begin
            op_r <= OP_ERASE;
            ptr_r <= {csec, {SECT_AW{1'b0}}};
            end_r <= {csec, {SECT_AW{1'b1}}};
            emask_r <= '1;
            cnt_r <= ers_cyc_r;
          end
        end
        EV_ID: mode_r <= MD_ID;
        EV_EXIT: begin
          mode_r <= MD_READ;
          fail_r <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // word array
  always_ff @(posedge CORE_CLK) begin
    if (!rst && step) begin
      if (op_r == OP_PROG) begin
        mem[ptr_r] <= mem[ptr_r] & pd_r;
      end else if (emask_r[psec]) begin
        mem[ptr_r] <= '1;
      end
    end
  end

  // data pins
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      DQ_OE <= 1'b0;
      DQ_O <= '0;
    end else begin
      DQ_OE <= ~ce_n_s & ~oe_n_s;
      DQ_O <= '0;
      unique case (mode_r)
        MD_READ: DQ_O <= mem[a_s];
        MD_ID: begin
          if (a_s[SECT_AW-1:0] == `FLK_LOCK_OFS) begin
            DQ_O[1] <= hard_r[rsec];
            DQ_O[0] <= soft_r[rsec];
          end
        end
        MD_STAT: begin
          DQ_O[`FLK_ST_RDY] <= op_r == OP_IDLE;
          DQ_O[`FLK_ST_FAIL] <= fail_r;
        end
        default: ;
      endcase
    end
  end

  // software registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prog_cyc_r <= `FLK_PROG_RST;
      ers_cyc_r <= `FLK_ERS_RST;
    end else if (wreq.wr) begin
      if (wreq.addr == `FLK_OFS_PROG) begin
        if (wreq.strb[0]) prog_cyc_r[7:0] <= wreq.data[7:0];
        if (wreq.strb[1]) prog_cyc_r[15:8] <= wreq.data[15:8];
      end
      if (wreq.addr == `FLK_OFS_ERS) begin
        if (wreq.strb[0]) ers_cyc_r[7:0] <= wreq.data[7:0];
        if (wreq.strb[1]) ers_cyc_r[15:8] <= wreq.data[15:8];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (raddr)
      `FLK_OFS_PROG: rd_mux[15:0] = prog_cyc_r;
      `FLK_OFS_ERS: rd_mux[15:0] = ers_cyc_r;
      `FLK_OFS_STAT: rd_mux[6:0] = {mode_r, op_r, fail_r, seq_r != SQ_IDLE,
        op_r != OP_IDLE};
      `FLK_OFS_LOCK: rd_mux[31:0] = {{(16 - NSECT){1'b0}}, hard_r,
        {(16 - NSECT){1'b0}}, soft_r};
      default: ;
    endcase
  end

  flk_axil u_axil (
    .clk(CORE_CLK),
    .rst(SRST),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wreq(wreq),
    .raddr(raddr),
    .rdata_in(rd_mux)
  );
endmodule

// File: dv/flk_top_properties.sv
// assertions on the sequencer top ports
`timescale 1ns/1ps
module flk_chk (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic RESET_N,
  input wire logic DQ_OE,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_take;
    ARVALID && ARREADY;
  endsequence
  a_reset_float: assert property (!RESET_N [*5] |-> !DQ_OE)
    else $error("data lines driven while reset pin low");
  a_write_resp: assert property (s_wr_take |-> ##[1:2] BVALID)
    else $error("write response late");
  a_write_once: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response repeated");
  a_busy_no_aw: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted before response taken");
  a_read_resp: assert property (s_rd_take |-> ##[1:3] RVALID)
    else $error("read response late");
  a_read_once: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read response repeated");
  a_unmapped_rd: assert property (ARVALID && ARREADY && ARADDR > 8'h0C |->
    ##[1:3] (RVALID && RRESP == 2'h2 && RDATA == 32'h0))
    else $error("unmapped read not refused");
  a_srst_quiet: assert property (disable iff (1'b0)
    SRST |=> !BVALID && !RVALID)
    else $error("response pending after reset");
endmodule

// File: dv/flk_host.sv
// host model driving the flash strobe pins
`timescale 1ns/1ps
`include "flk_regs.svh"
module flk_host (
  input wire logic clk,
  output logic we_n,
  output logic ce_n,
  output logic oe_n,
  output logic [4:0] addr,
  output logic [15:0] dq_i,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe
);
  initial begin
    {we_n, ce_n, oe_n} = 3'h7;
    addr = 5'h00;
    dq_i = 16'h0000;
  end
  // one write cycle, strobe five clocks low then high
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    ce_n <= 1'b0;
    addr <= a;
    dq_i <= d;
    we_n <= 1'b0;
    repeat (5) @(posedge clk);
    we_n <= 1'b1;
    repeat (5) @(posedge clk);
    ce_n <= 1'b1;
    dq_i <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    {ce_n, oe_n} <= 2'h0;
    addr <= a;
    repeat (8) @(posedge clk);
    // lines left undriven read back inverted
    d = dq_oe ? dq_o : ~dq_o;
    {ce_n, oe_n} <= 2'h3;
  endtask
  task automatic six(input logic [4:0] a, input logic [15:0] c);
    wr(5'h00, `FLK_CMD_C1);
    wr(5'h00, `FLK_CMD_C2);
    wr(5'h00, `FLK_CMD_ERS);
    wr(5'h00, `FLK_CMD_C1);
    wr(5'h00, `FLK_CMD_C2);
    wr(a, c);
  endtask
  task automatic prog(input logic [4:0] a, input logic [15:0] d);
    wr(5'h00, `FLK_CMD_C1);
    wr(5'h00, `FLK_CMD_C2);
    wr(5'h00, `FLK_CMD_PROG);
    wr(a, d);
  endtask
  task automatic unl(input logic [4:0] a);
    wr(a, `FLK_CMD_UNL1);
    wr(a, `FLK_CMD_UNL2);
  endtask
  task automatic idm;
    wr(5'h00, `FLK_CMD_C1);
    wr(5'h00, `FLK_CMD_C2);
    wr(5'h00, `FLK_CMD_ID);
  endtask
endmodule

// File: dv/flk_top_tb.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "flk_regs.svh"
module flk_top_tb;
  logic CORE_CLK, SRST, RESET_N, WE_N, CE_N, OE_N, WP, DQ_OE;
  logic [4:0] ADDR;
  logic [15:0] DQ_I, DQ_O, dv;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0] WSTRB;
  logic AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, rr;
  int fail_count, comparisons;
  flk_top dut_u (.CORE_CLK, .SRST, .RESET_N, .WE_N, .CE_N, .OE_N, .WP,
    .ADDR, .DQ_I, .DQ_O, .DQ_OE, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  flk_host host_u (.clk(CORE_CLK), .we_n(WE_N), .ce_n(CE_N), .oe_n(OE_N),
    .addr(ADDR), .dq_i(DQ_I), .dq_o(DQ_O), .dq_oe(DQ_OE));
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic to;
    fail_count++;
    $display("CHECK FAILED wait exp done got timeout");
    test_done();
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        rr = BRESP;
        BREADY <= 1'b0;
      end
      n++;
      if (n > 50) to();
    end while (BREADY);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        rv = RDATA;
        rr = RRESP;
        RREADY <= 1'b0;
      end
      n++;
      if (n > 50) to();
    end while (RREADY);
  endtask
  task automatic rg(input logic [7:0] a, input logic [31:0] m, e);
    axr(a);
    chk("register", e, rv & m);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      axr(`FLK_OFS_STAT);
      n++;
      if (n > 3000) to();
    end while (rv[0] !== 1'b0);
  endtask
  task automatic fchk(input logic [4:0] a, input logic [15:0] e);
    host_u.rd(a, dv);
    chk("flash word", 32'(e), 32'(dv));
  endtask
  task automatic lk(input logic [4:0] a, input logic [1:0] e);
    host_u.rd(a, dv);
    chk("lock code", 32'(e), 32'(dv[1:0]));
  endtask
  initial begin
    repeat (100000) @(posedge CORE_CLK);
    to();
  end
  initial begin
    {SRST, RESET_N, WP} = 3'h6;
    {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    fail_count = 0;
    comparisons = 0;
    repeat (16) @(posedge CORE_CLK);
    SRST <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    rg(`FLK_OFS_PROG, 32'hFFFF, 32'(`FLK_PROG_RST));
    rg(`FLK_OFS_ERS, 32'hFFFF, 32'(`FLK_ERS_RST));
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000000FF);
    axr(8'h40);
    chk_resp("read resp", `FLK_RESP_ERR, rr);
    axw(8'h40, 32'h0);
    chk_resp("write resp", `FLK_RESP_ERR, rr);
    axw(`FLK_OFS_PROG, 32'h0);
    chk_resp("write resp", `FLK_RESP_OK, rr);
    axw(`FLK_OFS_ERS, 32'h0);
    rg(`FLK_OFS_PROG, 32'hFFFF, 32'h0);
    rg(`FLK_OFS_ERS, 32'hFFFF, 32'h0);
    $display("registers test done");
    host_u.prog(5'h01, 16'h1234);
    idle();
    host_u.rd(5'h01, dv);
    chk("status bits", 32'h3, 32'({dv[7], dv[5]}));
    rg(`FLK_OFS_STAT, 32'h4, 32'h4);
    host_u.wr(5'h00, `FLK_CMD_EXIT);
    host_u.unl(5'h00);
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000000FE);
    host_u.six(5'h00, `FLK_CMD_PLANE);
    idle();
    rg(`FLK_OFS_STAT, 32'h4, 32'h4);
    host_u.wr(5'h00, `FLK_CMD_EXIT);
    host_u.six(5'h00, `FLK_CMD_SECT);
    idle();
    fchk(5'h01, 16'hFFFF);
    host_u.prog(5'h01, 16'h1234);
    idle();
    fchk(5'h01, 16'h1234);
    host_u.prog(5'h01, 16'hFF0F);
    idle();
    fchk(5'h01, 16'h1204);
    $display("erase and program test done");
    host_u.six(5'h04, `FLK_CMD_HARD);
    host_u.idm();
    lk(5'h02, 2'h0);
    lk(5'h06, 2'h3);
    lk(5'h0A, 2'h1);
    host_u.wr(5'h00, `FLK_CMD_EXIT);
    host_u.unl(5'h04);
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000200FE);
    WP <= 1'b1;
    host_u.unl(5'h04);
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000200FC);
    host_u.idm();
    lk(5'h06, 2'h2);
    host_u.wr(5'h00, `FLK_CMD_EXIT);
    host_u.six(5'h04, `FLK_CMD_SECT);
    idle();
    fchk(5'h04, 16'hFFFF);
    WP <= 1'b0;
    $display("lock test done");
    host_u.six(5'h00, `FLK_CMD_SOFT);
    host_u.unl(5'h08);
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000200F9);
    axw(`FLK_OFS_ERS, 32'h40);
    host_u.six(5'h00, `FLK_CMD_CHIP);
    rg(`FLK_OFS_STAT, 32'h1, 32'h1);
    host_u.prog(5'h08, 16'h0000);
    idle();
    fchk(5'h01, 16'h1204);
    fchk(5'h08, 16'hFFFF);
    $display("chip erase test done");
    host_u.wr(5'h00, `FLK_CMD_C1);
    rg(`FLK_OFS_STAT, 32'h2, 32'h2);
    host_u.wr(5'h00, 16'h0012);
    rg(`FLK_OFS_STAT, 32'h2, 32'h0);
    fchk(5'h01, 16'h1204);
    host_u.six(5'h00, `FLK_CMD_CHIP);
    repeat (20) @(posedge CORE_CLK);
    RESET_N <= 1'b0;
    host_u.rd(5'h01, dv);
    chk("data enable", 32'h0, 32'(DQ_OE));
    RESET_N <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    rg(`FLK_OFS_STAT, 32'h7F, 32'h0);
    rg(`FLK_OFS_LOCK, 32'hFFFFFFFF, 32'h000000FF);
    fchk(5'h01, 16'h1204);
    $display("reset pin test done");
    test_done();
  end
endmodule
bind flk_top flk_chk chk_u (.CORE_CLK, .SRST, .RESET_N, .DQ_OE, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARADDR, .ARVALID,
  .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
